// ==== design/tmirq_consts.vh ====
`ifndef TMIRQ_CONSTS_VH
`define TMIRQ_CONSTS_VH
// ===========================================================
// register byte offsets
`define OFS_TM_FLAG 12'h000
`define OFS_TM_EN 12'h004
`define OFS_GRP 12'h008
`define OFS_CTRL 12'h00c
`define OFS_STACK 12'h010
`define OFS_EVT 12'h014
`define OFS_EVT_MASK 12'h018
`define OFS_SAVED_PC 12'h01c
// ===========================================================
// field positions
`define GRP_FLAG_LSB 0
`define GRP_EN_LSB 8
`define CTRL_GIE 0
`define CTRL_SLEEP 1
`define CTRL_RETURN_FROM_INTERRUPT 2
`define CTRL_RET 3
`define CTRL_ACK 4
`define EVT_ENTRY 0
`define EVT_WAKE 1
`define EVT_OVF 2
// ===========================================================
// reset values
`define RST_GIE 1'b0
`define RST_WORD 32'h0000_0000
`endif

// ==== design/tm_flag_cell.v ====
`timescale 1ns/100ps
// one request flag: a match event sets it, a software clear drops it,
// the set wins when both land in the same cycle
module tm_flag_cell (
  // clock and reset
  input wire hclk,
  input wire hresetn,
  // controls
  input wire match,
  input wire sw_set,
  input wire sw_clr,
  // state
  output reg flag_r,
  output wire rise
);
  reg prev_r;
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      flag_r <= 1'b0;
      prev_r <= 1'b0;
    end else begin
      prev_r <= flag_r;
      if (match || sw_set)
        flag_r <= 1'b1;
      else if (sw_clr)
        flag_r <= 1'b0;
    end
  end
  assign rise = flag_r & ~prev_r;
endmodule

// ==== design/pc_stack.v ====
`timescale 1ns/100ps
// return-address stack; only the program counter is kept here
module pc_stack #(
  parameter DEPTH = 16,
  parameter AW = 4,
  parameter PCW = 16
) (
  // clock and reset
  input wire hclk,
  input wire hresetn,
  // push and pop
  input wire push,
  input wire pop,
  input wire [PCW-1:0] push_pc,
  output reg [PCW-1:0] top_r,
  output wire full,
  output wire empty,
  output wire [AW:0] level
);
  reg [PCW-1:0] mem [0:DEPTH-1];
  reg [AW:0] cnt_r;
  // after a pop the entry below the popped one becomes the new top
  localparam [AW-1:0] BELOW = 2;
  assign full = (cnt_r == DEPTH[AW:0]);
  assign empty = (cnt_r == {(AW+1){1'b0}});
  assign level = cnt_r;
  always @(posedge hclk) begin
    if (push && !full)
      mem[cnt_r[AW-1:0]] <= push_pc;
  end
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_r <= {(AW+1){1'b0}};
      top_r <= {PCW{1'b0}};
    end else if (push && !full) begin
      cnt_r <= cnt_r + 1'b1;
      top_r <= push_pc;
    end else if (pop && !empty) begin
      cnt_r <= cnt_r - 1'b1;
      if (cnt_r == {{AW{1'b0}}, 1'b1})
        top_r <= {PCW{1'b0}};
      else
        top_r <= mem[cnt_r[AW-1:0] - BELOW];
    end
  end
endmodule

// ==== design/tm_irq_ctrl.v ====
// The AHB-Lite slave port and the register offsets are this design's own decisions.
`timescale 1ns/100ps
// Behaviour
// RQ1 - each timer has a P-match and an A-match flag, each with an enable
// RQ2 - a comparator P or A match sets that timer's flag
// RQ3 - a group flag sets whenever a timer flag below it becomes set
// RQ4 - vector taken only with global, timer, group enables and stack not full
// RQ5 - servicing clears global enable and group flag, keeps timer flags
// RQ6 - handler software clears the individual timer flag itself
// RQ7 - a set flag stays set until serviced or cleared, enable regardless
// RQ8 - in sleep or idle, any flag rising wakes, enables ignored; this design has no idle mode, only ST_SLEEP wakes
// RQ9 - software may pre-set a flag to block its wake-up
// RQ10 - interrupt entry pushes only the program counter
// RQ11 - return-from-interrupt returns and sets the global enable
// RQ12 - plain subroutine return leaves the global enable cleared
// RQ13 - handlers should avoid subroutine calls; stack may overflow
`include "tmirq_consts.vh"
module tm_irq_ctrl #(
  parameter NTM = 4,
  parameter NGRP = 2,
  parameter PCW = 16,
  parameter SDEPTH = 16,
  parameter SAW = 4
) (
  // clock and reset
  input wire hclk,
  input wire hresetn,
  // ahb-lite slave
  input wire hsel,
  input wire [11:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output reg [31:0] hrdata,
  output wire hreadyout,
  output wire hresp,
  // timer match events, one-cycle pulses
  input wire [NTM-1:0] tm_p_match,
  input wire [NTM-1:0] tm_a_match,
  // core side
  input wire [PCW-1:0] core_pc,
  input wire [NTM-1:0] tm_group_sel,
  output wire irq_req,
  output reg [PCW-1:0] vector_pc_r,
  output wire wake,
  output wire irq
);
  localparam ST_RUN = 2'b00;
  localparam ST_SLEEP = 2'b01;
  localparam ST_ISR = 2'b10;

  // ===========================================================
  // bus slave
  reg wr_pend_r;
  reg [11:0] addr_r;
  wire take = hsel & hready & htrans[1];
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_r <= 1'b0;
      addr_r <= 12'h000;
    end else if (hready) begin
      wr_pend_r <= take & hwrite;
      addr_r <= haddr;
    end
  end
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  wire wr = wr_pend_r;
  wire wr_flag = wr & (addr_r == `OFS_TM_FLAG);
  wire wr_en = wr & (addr_r == `OFS_TM_EN);
  wire wr_grp = wr & (addr_r == `OFS_GRP);
  wire wr_ctrl = wr & (addr_r == `OFS_CTRL);
  wire wr_evt = wr & (addr_r == `OFS_EVT);
  wire wr_mask = wr & (addr_r == `OFS_EVT_MASK);

  // ===========================================================
  // timer request flags: [NTM-1:0] are P, [2*NTM-1:NTM] are A
  wire [2*NTM-1:0] tm_flag;
  wire [2*NTM-1:0] tm_rise;
  wire [2*NTM-1:0] tm_match = {tm_a_match, tm_p_match};
  // writing 1 clears a flag; writing to the upper half sets (wake blocking)
  wire [2*NTM-1:0] sw_clr = wr_flag ? hwdata[2*NTM-1:0] : {2*NTM{1'b0}};
  wire [2*NTM-1:0] sw_set = wr_flag ? hwdata[16+2*NTM-1:16] : {2*NTM{1'b0}};
  genvar g;
  generate
    for (g = 0; g < 2*NTM; g = g + 1) begin : flg
      // RQ1 RQ2 RQ7 sticky match flag
      tm_flag_cell u_cell (
        .hclk(hclk),
        .hresetn(hresetn),
        .match(tm_match[g]),
        .sw_set(sw_set[g]),
        .sw_clr(sw_clr[g]),
        .flag_r(tm_flag[g]),
        .rise(tm_rise[g])
      );
    end
  endgenerate

  reg [2*NTM-1:0] tm_en_r;
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn)
      tm_en_r <= {2*NTM{1'b0}};
    else if (wr_en)
      tm_en_r <= hwdata[2*NTM-1:0];
  end

  // ===========================================================
  // group flags; tm_group_sel picks group 1 for a timer, else group 0
  wire [NTM-1:0] tm_req = (tm_flag[NTM-1:0] & tm_en_r[NTM-1:0]) |
                          (tm_flag[2*NTM-1:NTM] & tm_en_r[2*NTM-1:NTM]);
  wire [NTM-1:0] tm_rise_any = tm_rise[NTM-1:0] | tm_rise[2*NTM-1:NTM];
  wire [NTM-1:0] tm_req_raw = tm_rise_any & (tm_req | ~tm_req);
  reg [NGRP-1:0] grp_flag_r;
  reg [NGRP-1:0] grp_en_r;
  reg [NGRP-1:0] grp_set;
  reg [NGRP-1:0] grp_req;
  reg [NGRP-1:0] grp_clr_svc;
  integer i;
  always @* begin
    grp_set = {NGRP{1'b0}};
    grp_req = {NGRP{1'b0}};
    for (i = 0; i < NTM; i = i + 1) begin
      grp_set[tm_group_sel[i] ? 1 : 0] = grp_set[tm_group_sel[i] ? 1 : 0] | tm_req_raw[i];
      grp_req[tm_group_sel[i] ? 1 : 0] = grp_req[tm_group_sel[i] ? 1 : 0] | tm_req[i];
    end
  end

  // ===========================================================
  // entry and return
  reg gie_r;
  reg [1:0] state_r;
  wire [SAW:0] slevel;
  wire sfull;
  wire sempty;
  wire [PCW-1:0] stop;
  wire ack = wr_ctrl & hwdata[`CTRL_ACK];
  wire do_return_from_interrupt = wr_ctrl & hwdata[`CTRL_RETURN_FROM_INTERRUPT];
  wire do_ret = wr_ctrl & hwdata[`CTRL_RET];
  // RQ4 all four conditions
  wire [NGRP-1:0] grp_pend = grp_flag_r & grp_en_r & grp_req;
  assign irq_req = gie_r & ~sfull & (|grp_pend) & (state_r != ST_SLEEP);
  // lower group number wins when both are pending
  wire svc_grp = ~grp_pend[0];
  wire entry = irq_req & ack;
  always @* begin
    grp_clr_svc = {NGRP{1'b0}};
    if (entry)
      grp_clr_svc[svc_grp ? 1 : 0] = 1'b1;
  end
  wire [NGRP-1:0] grp_sw_clr = wr_grp ? hwdata[NGRP-1:0] : {NGRP{1'b0}};
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      grp_flag_r <= {NGRP{1'b0}};
      grp_en_r <= {NGRP{1'b0}};
    end else begin
      // RQ3 RQ5 set beats clear, service clears only the group flag
      grp_flag_r <= grp_set | (grp_flag_r & ~grp_clr_svc & ~grp_sw_clr);
      if (wr_grp)
        grp_en_r <= hwdata[`GRP_EN_LSB+NGRP-1:`GRP_EN_LSB];
    end
  end

  // RQ10 only the pc is pushed
  pc_stack #(
    .DEPTH(SDEPTH),
    .AW(SAW),
    .PCW(PCW)
  ) u_stack (
    .hclk(hclk),
    .hresetn(hresetn),
    .push(entry),
    .pop(do_return_from_interrupt | do_ret),
    .push_pc(core_pc),
    .top_r(stop),
    .full(sfull),
    .empty(sempty),
    .level(slevel)
  );

  // ===========================================================
  // control state
  wire wake_ev = (state_r == ST_SLEEP) & (|tm_rise);
  wire ovf_ev = ack & sfull;
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      gie_r <= `RST_GIE;
      state_r <= ST_RUN;
      vector_pc_r <= {PCW{1'b0}};
    end else begin
      if (entry) begin
        // RQ5 entry drops the global enable
        gie_r <= 1'b0;
        vector_pc_r <= {{(PCW-1){1'b0}}, svc_grp};
      end else if (do_return_from_interrupt && !sempty) begin
        // RQ11 return and re-enable
        gie_r <= 1'b1;
        vector_pc_r <= stop;
      end else if (do_ret && !sempty) begin
        // RQ12 return, enable untouched
        vector_pc_r <= stop;
      end else if (wr_ctrl) begin
        gie_r <= hwdata[`CTRL_GIE];
      end
      case (state_r)
        ST_RUN: begin
          if (entry)
            state_r <= ST_ISR;
          else if (wr_ctrl && hwdata[`CTRL_SLEEP])
            state_r <= ST_SLEEP;
        end
        // RQ8 any flag rise wakes, enables ignored; RQ9 pre-set blocks it
        ST_SLEEP: if (wake_ev) state_r <= ST_RUN;
        ST_ISR: if ((do_return_from_interrupt || do_ret) && slevel == {{SAW{1'b0}}, 1'b1}) state_r <= ST_RUN;
        default: state_r <= ST_RUN;
      endcase
    end
  end
  assign wake = wake_ev;

  // ===========================================================
  // event status and interrupt line
  reg [2:0] evt_r;
  reg [2:0] evt_mask_r;
  wire [2:0] evt_set = {ovf_ev, wake_ev, entry};
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      evt_r <= 3'h0;
      evt_mask_r <= 3'h0;
    end else begin
      evt_r <= evt_set | (evt_r & ~(wr_evt ? hwdata[2:0] : 3'h0));
      if (wr_mask)
        evt_mask_r <= hwdata[2:0];
    end
  end
  assign irq = |(evt_r & evt_mask_r);

  // ===========================================================
  // read data, registered in the address phase
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn)
      hrdata <= `RST_WORD;
    else if (take && !hwrite) begin
      hrdata <= `RST_WORD;
      case (haddr)
        `OFS_TM_FLAG: hrdata[2*NTM-1:0] <= tm_flag;
        `OFS_TM_EN: hrdata[2*NTM-1:0] <= tm_en_r;
        `OFS_GRP: hrdata <= {{(24-NGRP){1'b0}}, grp_en_r, {(8-NGRP){1'b0}}, grp_flag_r};
        `OFS_CTRL: hrdata <= {30'h0, state_r == ST_SLEEP, gie_r};
        `OFS_STACK: hrdata[SAW:0] <= slevel;
        `OFS_EVT: hrdata[2:0] <= evt_r;
        `OFS_EVT_MASK: hrdata[2:0] <= evt_mask_r;
        `OFS_SAVED_PC: hrdata[PCW-1:0] <= stop;
        default: hrdata <= `RST_WORD;
      endcase
    end
  end
endmodule

// ==== test/tm_timers.sv ====
`timescale 1ns/100ps
// ====
// timer side: match pulses last one cycle only
module tm_timers #(
  parameter N = 4
) (
  // clock
  input wire hclk,
  // matches
  output logic [N-1:0] p,
  output logic [N-1:0] a
);
  initial p = '0;
  initial a = '0;
  task fire(input bit at, input int k);
    if (at) a[k] <= 1'b1;
    else p[k] <= 1'b1;
    @(posedge hclk);
    p <= '0;
    a <= '0;
  endtask
endmodule

// ==== test/tm_irq_ctrl_chk.sv ====
`timescale 1ns/100ps
module tm_irq_ctrl_chk #(
  parameter NTM = 4,
  parameter NGRP = 2,
  parameter PCW = 16
) (
  // clock and bus
  input wire hclk,
  input wire hresetn,
  input wire hsel,
  input wire [11:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [31:0] hwdata,
  input wire hready,
  // events and core
  input wire [NTM-1:0] tm_p_match,
  input wire [NTM-1:0] tm_a_match,
  input wire [PCW-1:0] core_pc,
  input wire irq_req,
  input wire [PCW-1:0] vector_pc_r,
  input wire wake
);
  // ====
  // shadow of the write side; gie follows the ctrl write rules
  logic wq, gie, slp;
  logic [11:0] aq;
  logic [2:0] mh;
  logic [PCW-1:0] pcq;
  wire cw = wq && aq == 12'h00c;
  wire ent = cw && hwdata[4] && irq_req;
  wire m = |{tm_p_match, tm_a_match};
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wq <= 1'b0;
      aq <= 12'h000;
      gie <= 1'b0;
      slp <= 1'b0;
      mh <= 3'h0;
      pcq <= '0;
    end else begin
      wq <= hsel && hready && htrans[1] && hwrite;
      if (hready) aq <= haddr;
      mh <= {mh[1:0], m};
      if (ent) gie <= 1'b0;
      else if (cw && hwdata[2]) gie <= 1'b1;
      else if (cw && !hwdata[3]) gie <= hwdata[0];
      if (ent) pcq <= core_pc;
      if (wake) slp <= 1'b0;
      else if (cw && hwdata[1]) slp <= 1'b1;
    end
  end
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  AST_ENTRY_DROPS_REQ: assert property (ent |=> !irq_req)
    else $error("request stays after entry");
  AST_ENTRY_VECTOR: assert property (ent |=> vector_pc_r < NGRP)
    else $error("bad vector after entry");
  AST_REQ_NEEDS_GIE: assert property (irq_req |-> gie)
    else $error("request with global enable low");
  AST_REQ_AWAKE: assert property (irq_req |-> !slp)
    else $error("request while asleep");
  AST_REQ_CAUSE: assert property ($rose(irq_req) |-> |mh || $past(wq) || $past(wake))
    else $error("request rose without cause");
  AST_RET_POPS_PC: assert property (cw && |hwdata[3:2] && !hwdata[4] |=> vector_pc_r == pcq)
    else $error("return gave wrong pc");
  AST_WAKE_ASLEEP: assert property (wake |-> slp)
    else $error("wake while awake");
  AST_WAKE_CAUSE: assert property (wake |-> m || mh[0] || $past(wq))
    else $error("wake without flag rise");
  cover property (ent);
  cover property (wake);
  cover property (cw && hwdata[2]);
endmodule
bind tm_irq_ctrl tm_irq_ctrl_chk #(.NTM(NTM), .NGRP(NGRP), .PCW(PCW)) u_chk (.hclk, .hresetn,
  .hsel, .haddr, .htrans, .hwrite, .hwdata, .hready, .tm_p_match, .tm_a_match, .core_pc,
  .irq_req, .vector_pc_r, .wake);

// ==== test/tb_tm_irq_ctrl.sv ====
`timescale 1ns/100ps
module tb_tm_irq_ctrl;
  // ====
  // bench signals
  logic hclk, hresetn, hsel, hwrite, rdp, wk;
  logic [11:0] haddr;
  logic [1:0] htrans;
  logic [31:0] hwdata, q[$];
  logic [15:0] core_pc;
  logic [3:0] gsel;
  wire [31:0] hrdata;
  wire [15:0] vpc;
  wire [3:0] p, a;
  wire hreadyout, hresp, irq_req, wake, irq;
  int miscompares, checks, s, t, k;
  initial begin
    hclk = 0;
    forever #4 hclk = ~hclk;
  end
  tm_irq_ctrl u_tm_irq_ctrl (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
    .hsize(3'b010), .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp,
    .tm_p_match(p), .tm_a_match(a), .core_pc, .tm_group_sel(gsel), .irq_req,
    .vector_pc_r(vpc), .wake, .irq);
  tm_timers u_tm_timers (.hclk, .p, .a);
  // ====
  // helpers
  function int rnd();
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction
  task chk(string n, logic [31:0] e, logic [31:0] g);
    checks++;
    if (g !== e) begin
      miscompares++;
      $display("ERROR %s exp %h got %h", n, e, g);
    end
  endtask
  task tick(int n);
    repeat (n) @(posedge hclk);
  endtask
  task bus(logic w, logic [11:0] ad, logic [31:0] d);
    hsel <= 1'b1;
    hwrite <= w;
    haddr <= ad;
    htrans <= 2'b10;
    tick(1);
    while (!hreadyout) tick(1);
    htrans <= 2'b00;
    hwdata <= d;
    tick(1);
    while (!hreadyout) tick(1);
  endtask
  task wr(logic [11:0] ad, logic [31:0] d);
    bus(1'b1, ad, d);
  endtask
  task rd(logic [11:0] ad, logic [31:0] e);
    q.push_back(e);
    bus(1'b0, ad, 32'h0);
  endtask
  task complete_run();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // read data is compared in its data phase, wake pulses are caught
  always @(posedge hclk) begin
    if (rdp) chk("hrdata", q.pop_front(), hrdata);
    rdp = hsel && htrans[1] && !hwrite && hreadyout;
    if (wake) wk = 1'b1;
  end
  initial begin
    tick(5000);
    miscompares++;
    complete_run();
  end
  // ====
  // scenarios
  initial begin
    s = 8595;
    {hresetn, hsel, hwrite, haddr, htrans, hwdata, rdp, wk} = '0;
    core_pc = 16'(rnd());
    gsel = 4'(rnd());
    tick(6);
    hresetn <= 1'b1;
    for (int i = 0; i < 9; i++) rd(12'(i * 4), 32'h0);
    for (int i = 0; i < 8; i++) begin
      u_tm_timers.fire(i > 3, i % 4);
      rd(12'h000, (1 << (i + 1)) - 1);
    end
    rd(12'h008, {30'h0, |gsel, |(~gsel)});
    wr(12'h000, 32'hff);
    wr(12'h008, 32'h3);
    rd(12'h000, 32'h0);
    t = rnd() & 3;
    wr(12'h004, 1 << t);
    wr(12'h008, 32'h300);
    wr(12'h00c, 32'h1);
    u_tm_timers.fire(0, t);
    tick(2);
    chk("irq_req", 1, irq_req);
    wr(12'h00c, 32'h10);
    tick(1);
    chk("vector", gsel[t], vpc);
    chk("irq_req", 0, irq_req);
    rd(12'h000, 1 << t);
    rd(12'h008, 32'h300);
    rd(12'h010, 32'h1);
    rd(12'h01c, core_pc);
    u_tm_timers.fire(1, t);
    tick(2);
    chk("irq_req", 0, irq_req);
    // the handler makes no nested call, so one stack entry suffices
    wr(12'h00c, 32'h8);
    tick(1);
    chk("vector", core_pc, vpc);
    chk("irq_req", 0, irq_req);
    wr(12'h00c, 32'h1);
    wr(12'h00c, 32'h10);
    wr(12'h000, 1 << (4 + t));
    u_tm_timers.fire(1, t);
    wr(12'h00c, 32'h4);
    tick(1);
    chk("irq_req", 1, irq_req);
    chk("vector", core_pc, vpc);
    wr(12'h00c, 32'h0);
    wr(12'h004, 32'hff);
    wr(12'h000, 32'hff);
    wr(12'h014, 32'h7);
    wr(12'h00c, 32'h2);
    wk = 1'b0;
    k = rnd() & 7;
    u_tm_timers.fire(k > 3, k % 4);
    tick(2);
    chk("wake", 1, wk);
    chk("irq", 0, irq);
    wr(12'h018, 32'h2);
    tick(1);
    chk("irq", 1, irq);
    rd(12'h014, 32'h2);
    wr(12'h014, 32'h2);
    tick(1);
    chk("irq", 0, irq);
    wr(12'h000, 32'hff | (1 << (16 + k)));
    wr(12'h00c, 32'h2);
    wk = 1'b0;
    u_tm_timers.fire(k > 3, k % 4);
    tick(2);
    chk("wake", 0, wk);
    u_tm_timers.fire(k < 4, k % 4);
    tick(2);
    chk("wake", 1, wk);
    chk("hresp", 0, hresp);
    complete_run();
  end
endmodule
